// File: rtl/slml_loader.sv
// serial load, latch and refresh core of a 4-character 5x7 led matrix driver.
// assumes serial pins from the host are asynchronous and run far below clk;
// software reaches status and debug registers over a 32-bit apb slave.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// - shift data while enable low, serial clock rising
// - select low means dots, high means control
// - select captured at enable falling edge
// - enable rising with clock low latches data
// - reset pin low clears both control words
// - reset pin leaves dot contents alone
// - reset forces sleep, leds blanked
// - osc select low external, high internal
// - tick pin drives internal osc, else input
// - dim input high turns all leds off
// - serial output forwards data for chaining
// - 160-bit dots, two 7-bit words, refresh
// - one dot bit drives exactly one led
// - one chip serves four 5x7 characters
// - two chips chain into 320-bit register
// - dot one lights led, zero darkens it
// - eight control bits msb first, d7 picks
// - word 0 d6 low sleeps, keeps contents
// - word 1 d1 divides external osc by 8
module slml_loader #(
  parameter int DOT_N = slml_pkg::DOT_BITS     // dots per chip, one per led
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // serial host pins
  input  wire logic                        serialClk,
  input  wire logic                        serialIn,
  input  wire logic                        chipEnableN,
  input  wire logic                        target_choice,
  input  wire logic                        clearPinN,
  input  wire logic                        oscSelect,
  input  wire logic                        dim_all_in,
  output logic                             serialOut,
  // display tick pin, split into its three signals
  input  wire logic                        display_tick_pin_in,
  output logic                             display_tick_pin_out,
  output logic                             display_tick_pin_oe,
  // led drive
  output logic [DOT_N-1:0]                 ledDrive,
  output logic [slml_pkg::CW0_PEAK_W-1:0]  peakCurrent,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [slml_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr
);

  // whole state of the block in one record
  typedef struct packed {
    logic [DOT_N-1:0]                       dotShift;    // serial dot shift chain
    logic [DOT_N-1:0]                       dotLatch;    // dots shown on the leds
    logic [DOT_N-1:0]                       ledDrive;    // gated led outputs
    logic [slml_pkg::CTRL_BITS-1:0]         ctrlShift;   // control shift chain
    logic [slml_pkg::WORD_BITS-1:0]         cw0;         // brightness and sleep
    logic [slml_pkg::WORD_BITS-1:0]         cw1;         // data out mode, prescale
    logic                                   target;      // captured register select
    logic                                   loadPending; // enable rose, latch owed
    logic                                   serialOut;   // data out pin
    logic                                   tickOut;     // internal oscillator level
    logic                                   tickOe;      // tick pin driven by us
    logic [15:0]                            oscCnt;      // internal oscillator divider
    logic [slml_pkg::PRESCALE_W-1:0]        prescale;    // external oscillator divider
    logic [slml_pkg::REFRESH_W-1:0]         refreshCnt;  // display clocks in refresh
    logic [slml_pkg::CW0_PEAK_W-1:0]        peak;        // peak current setting out
    logic [15:0]                            oscDiv;      // software set half period
    logic [slml_pkg::DOTSEL_W-1:0]          dotSel;      // dot word for readback
    logic                                   prevSclk;    // edge detect history
    logic                                   prevCeN;
    logic                                   prevTick;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
  } slml_state_type;

  slml_state_type                  r_q;        // registered state
  slml_state_type                  r_d;        // next state
  logic [slml_pkg::PIN_COUNT-1:0]  pinRaw;     // pins gathered for the synchroniser
  logic [slml_pkg::PIN_COUNT-1:0]  pin;        // agreed pin levels

  // address decode, shared by the read and the write path
  function automatic logic hitReg(input logic [slml_pkg::ADDR_W-1:0] a,
                                  input logic [slml_pkg::ADDR_W-1:0] off);
    hitReg = (a == off);
  endfunction : hitReg

  // gather every asynchronous pin in the fixed package order
  always_comb begin
    pinRaw                        = '0;
    pinRaw[slml_pkg::PIN_SCLK]    = serialClk;
    pinRaw[slml_pkg::PIN_DIN]     = serialIn;
    pinRaw[slml_pkg::PIN_CE_N]    = chipEnableN;
    pinRaw[slml_pkg::PIN_TARGET]  = target_choice;
    pinRaw[slml_pkg::PIN_CLEAR_N] = clearPinN;
    pinRaw[slml_pkg::PIN_OSC_SEL] = oscSelect;
    pinRaw[slml_pkg::PIN_TICK]    = display_tick_pin_in;
    pinRaw[slml_pkg::PIN_DIM]     = dim_all_in;
  end

  // equal latency on every pin keeps setup and hold relations between them
  slml_pin_sync #(
    .W    (slml_pkg::PIN_COUNT),
    .IDLE (slml_pkg::PIN_IDLE)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pinIn    (pinRaw),
    .pinLevel (pin)
  );

  // next-state logic: serial entry, latching, refresh, led gating and apb
  always_comb begin
    logic sclk;
    logic din;
    logic ceN;
    logic sclkRise;
    logic ceFall;
    logic ceRise;
    logic sleep;
    logic internal;
    logic tickRise;
    logic dispTick;
    logic pwmOn;
    logic access;
    logic [31:0] rd;
    logic        err;
    sclk     = pin[slml_pkg::PIN_SCLK];
    din      = pin[slml_pkg::PIN_DIN];
    ceN      = pin[slml_pkg::PIN_CE_N];
    sclkRise = sclk && !r_q.prevSclk;
    ceFall   = !ceN && r_q.prevCeN;
    ceRise   = ceN && !r_q.prevCeN;
    sleep    = !r_q.cw0[slml_pkg::CW0_AWAKE_BIT];
    internal = pin[slml_pkg::PIN_OSC_SEL];
    tickRise = pin[slml_pkg::PIN_TICK] && !r_q.prevTick;
    dispTick = 1'b0;
    access   = psel && penable && !r_q.pready;
    rd       = '0;
    err      = 1'b0;
    r_d      = r_q;

    r_d.prevSclk = sclk;
    r_d.prevCeN  = ceN;
    r_d.prevTick = pin[slml_pkg::PIN_TICK];

    // select is taken once, at the start of a write
    if (ceFall) begin
      r_d.target      = pin[slml_pkg::PIN_TARGET];
      r_d.loadPending = 1'b0;
    end

    // shift on each serial clock rise while enable is low
    if (!ceN && sclkRise) begin
      if (!r_d.target) begin
        // last stage spills out so chips chain into one long register
        r_d.dotShift = {r_q.dotShift[DOT_N-2:0], din};
      end else begin
        r_d.ctrlShift = {r_q.ctrlShift[slml_pkg::CTRL_BITS-2:0], din};
      end
    end

    // enable rising arms the latch; clock low then fires it
    if (ceRise) begin
      r_d.loadPending = 1'b1;
    end
    if (r_d.loadPending && ceN && !sclk) begin
      r_d.loadPending = 1'b0;
      if (!r_q.target) begin
        r_d.dotLatch = r_d.dotShift;
      end else if (r_d.ctrlShift[slml_pkg::CTRL_SELECT_BIT]) begin
        // the word not selected keeps its value
        r_d.cw1 = r_d.ctrlShift[slml_pkg::WORD_BITS-1:0];
      end else begin
        r_d.cw0 = r_d.ctrlShift[slml_pkg::WORD_BITS-1:0];
      end
    end

    // reset pin clears the control words and any owed latch; dots are untouched
    if (!pin[slml_pkg::PIN_CLEAR_N]) begin
      r_d.cw0 = '0;
      r_d.cw1 = '0;
      r_d.loadPending = 1'b0;
    end

    // serial output: dot chain end, control chain end, or data in
    if (!r_d.target) begin
      r_d.serialOut = r_d.dotShift[DOT_N-1];
    end else if (r_q.cw1[slml_pkg::CW1_SIMUL_BIT]) begin
      r_d.serialOut = din;
    end else begin
      r_d.serialOut = r_d.ctrlShift[slml_pkg::CTRL_BITS-1];
    end

    // timebase: internal divider stops in sleep, else external pin
    r_d.tickOe = internal;
    if (internal) begin
      r_d.prescale = '0;
      if (sleep) begin
        r_d.oscCnt  = '0;
        r_d.tickOut = 1'b0;
      end else if (r_q.oscCnt >= r_q.oscDiv - 16'h0001) begin
        r_d.oscCnt  = '0;
        r_d.tickOut = !r_q.tickOut;
        dispTick    = !r_q.tickOut;
      end else begin
        r_d.oscCnt  = r_q.oscCnt + 16'h0001;
      end
    end else begin
      r_d.oscCnt  = '0;
      r_d.tickOut = 1'b0;
      if (tickRise) begin
        if (r_q.cw1[slml_pkg::CW1_PRESCALE_BIT]) begin
          r_d.prescale = r_q.prescale + 3'h1;
          dispTick     = (r_q.prescale == 3'(slml_pkg::PRESCALE - 1));
        end else begin
          dispTick = 1'b1;
        end
      end
    end

    // refresh counter wraps once per full display refresh
    if (dispTick && !sleep) begin
      r_d.refreshCnt = r_q.refreshCnt + 9'h001;
    end

    // pulse width brightness: on while the low count is under the duty
    pwmOn = (r_q.refreshCnt[slml_pkg::CW0_DUTY_W-1:0] <
             r_q.cw0[slml_pkg::CW0_DUTY_LSB +: slml_pkg::CW0_DUTY_W]);

    // each latched dot drives one led; sleep and dim override all
    if (sleep || pin[slml_pkg::PIN_DIM] || !pwmOn) begin
      r_d.ledDrive = '0;
    end else begin
      r_d.ledDrive = r_q.dotLatch;
    end
    r_d.peak = r_q.cw0[slml_pkg::CW0_PEAK_LSB +: slml_pkg::CW0_PEAK_W];

    // apb: answer one cycle into the access phase, write at that edge
    r_d.pready = access;
    if (access) begin
      if (hitReg(paddr, slml_pkg::STATUS_OFF)) begin
        rd[slml_pkg::ST_CW0_LSB +: slml_pkg::WORD_BITS]    = r_q.cw0;
        rd[slml_pkg::ST_CW1_LSB +: slml_pkg::WORD_BITS]    = r_q.cw1;
        rd[slml_pkg::ST_SLEEP_BIT]                         = sleep;
        rd[slml_pkg::ST_TARGET_BIT]                        = r_q.target;
        rd[slml_pkg::ST_PENDING_BIT]                       = r_q.loadPending;
        rd[slml_pkg::ST_REFRESH_LSB +: slml_pkg::REFRESH_W] = r_q.refreshCnt;
        err = pwrite;
      end else if (hitReg(paddr, slml_pkg::OSCDIV_OFF)) begin
        rd[15:0] = r_q.oscDiv;
        // a zero divider would wrap to the longest half period, so it is refused
        if (pwrite && pwdata[15:0] != 16'h0000) begin
          r_d.oscDiv = pwdata[15:0];
        end
      end else if (hitReg(paddr, slml_pkg::DOTSEL_OFF)) begin
        rd[slml_pkg::DOTSEL_W-1:0] = r_q.dotSel;
        if (pwrite) begin
          r_d.dotSel = pwdata[slml_pkg::DOTSEL_W-1:0];
        end
      end else if (hitReg(paddr, slml_pkg::DOTDATA_OFF)) begin
        // words past the end of the latch read as zero
        if (r_q.dotSel < 3'(slml_pkg::DOT_WORDS)) begin
          rd = r_q.dotLatch[32 * r_q.dotSel +: 32];
        end
        err = pwrite;
      end else begin
        err = 1'b1;                                            // unmapped address
      end
      r_d.prdata  = pwrite ? 32'h0000_0000 : rd;
      r_d.pslverr = err;
    end else begin
      r_d.pslverr = 1'b0;
    end
  end

  // one register stage for all state; the system reset is power-up only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q         <= '0;
      r_q.prevCeN <= 1'b1;
      r_q.oscDiv  <= slml_pkg::OSC_DIV_RESET;
      r_q.dotSel  <= slml_pkg::DOTSEL_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state flip-flops
  assign serialOut            = r_q.serialOut;
  assign display_tick_pin_out = r_q.tickOut;
  assign display_tick_pin_oe  = r_q.tickOe;
  assign ledDrive             = r_q.ledDrive;
  assign peakCurrent          = r_q.peak;
  assign prdata               = r_q.prdata;
  assign pready               = r_q.pready;
  assign pslverr              = r_q.pslverr;

endmodule : slml_loader

// File: rtl/slml_pkg.sv
// shared constants of the serial led matrix loader: pin order, control word
// fields, apb register map and display timing figures.
// assumes a single 125 MHz core clock and a 32-bit apb slave port.
package slml_pkg;

  // core clock rate, used to derive the internal oscillator divider
  localparam int CLK_MHZ          = 125;
  localparam int INT_OSC_KHZ      = 150;   // target internal display oscillator rate
  localparam logic [15:0] OSC_DIV_RESET = 16'((CLK_MHZ * 1000) / (2 * INT_OSC_KHZ));

  // storage sizes
  localparam int DOT_BITS         = 160;   // dot shift register length
  localparam int CTRL_BITS        = 8;     // control shift register length
  localparam int WORD_BITS        = 7;     // each of the two control words
  localparam int DOT_WORDS        = 5;     // 32-bit apb words covering the dot latch
  localparam int REFRESH_CYCLES   = 512;   // display clocks per full refresh
  localparam int REFRESH_W        = $clog2(REFRESH_CYCLES);
  localparam int PRESCALE         = 8;     // external oscillator divide
  localparam int PRESCALE_W       = $clog2(PRESCALE);

  // order of the synchronised pin inputs
  localparam int PIN_SCLK         = 0;
  localparam int PIN_DIN          = 1;
  localparam int PIN_CE_N         = 2;
  localparam int PIN_TARGET       = 3;
  localparam int PIN_CLEAR_N      = 4;
  localparam int PIN_OSC_SEL      = 5;
  localparam int PIN_TICK         = 6;
  localparam int PIN_DIM          = 7;
  localparam int PIN_COUNT        = 8;
  // idle levels of the pins: chip enable and clear high, everything else low
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 8'h14;

  // control shift register and control word fields
  localparam int CTRL_SELECT_BIT  = 7;     // high selects control word 1
  localparam int CW0_DUTY_LSB     = 0;
  localparam int CW0_DUTY_W       = 4;
  localparam int CW0_PEAK_LSB     = 4;
  localparam int CW0_PEAK_W       = 2;
  localparam int CW0_AWAKE_BIT    = 6;     // low means sleep
  localparam int CW1_SIMUL_BIT    = 0;     // high: data out follows data in while control is selected
  localparam int CW1_PRESCALE_BIT = 1;     // high: external oscillator divided

  // apb register map (byte addresses)
  localparam int ADDR_W           = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFF  = 8'h00;
  localparam logic [ADDR_W-1:0] OSCDIV_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] DOTSEL_OFF  = 8'h08;
  localparam logic [ADDR_W-1:0] DOTDATA_OFF = 8'h0c;

  // status register field positions
  localparam int ST_CW0_LSB       = 0;
  localparam int ST_CW1_LSB       = 8;
  localparam int ST_SLEEP_BIT     = 16;
  localparam int ST_TARGET_BIT    = 17;
  localparam int ST_PENDING_BIT   = 18;
  localparam int ST_REFRESH_LSB   = 23;

  // dot word select width and reset value
  localparam int DOTSEL_W         = 3;
  localparam logic [DOTSEL_W-1:0] DOTSEL_RESET = 3'h0;

endpackage : slml_pkg

// File: rtl/slml_pin_sync.sv
// three-stage synchroniser with agreement filter for a group of pins.
// assumes pins are asynchronous to clk; output changes only once the second
// and third stage agree, so a single metastable sample never reaches logic.
`timescale 1ns/1ns
module slml_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] IDLE = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinLevel
);

  // all state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;     // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;   // agreed level
  } slml_sync_state_type;

  slml_sync_state_type r_q;
  slml_sync_state_type r_d;
  logic [W-1:0]        agreed;

  // per-bit agreement: keep the old level while stages disagree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_filt
      assign agreed[gi] = (r_q.s2[gi] == r_q.s3[gi]) ? r_q.s3[gi] : r_q.filt[gi];
    end
  endgenerate

  // next state of the shift chain
  always_comb begin
    r_d      = r_q;
    r_d.s1   = pinIn;
    r_d.s2   = r_q.s1;
    r_d.s3   = r_q.s2;
    r_d.filt = agreed;
  end

  // registers start at the idle pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= {IDLE, IDLE, IDLE, IDLE};
    end else begin
      r_q <= r_d;
    end
  end

  assign pinLevel = r_q.filt;

endmodule : slml_pin_sync

// File: tb/slml_loader_assertions.sv
// checker of the loader: watches the top ports only, bound in below
// assumes one clock domain and pin inputs settled a few cycles after they move
`timescale 1ns/1ns
module slml_checker #(
  parameter int DOT_N = 160
) (
  input wire logic                           clk,
  input wire logic                           rst_n,
  input wire logic                           serialClk,
  input wire logic                           serialIn,
  input wire logic                           chipEnableN,
  input wire logic                           clearPinN,
  input wire logic                           oscSelect,
  input wire logic                           dim_all_in,
  input wire logic                           serialOut,
  input wire logic                           display_tick_pin_out,
  input wire logic                           display_tick_pin_oe,
  input wire logic [DOT_N-1:0]               ledDrive,
  input wire logic [slml_pkg::CW0_PEAK_W-1:0] peakCurrent,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pready,
  input wire logic                           pslverr
);
  // saturating counts of how long a pin has held its level
  logic [3:0] clrLo_q, clrHi_q, dim_q, ceLo_q, quiet_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // counts up while c holds, stops at 15, restarts on any change
  function automatic logic [3:0] sat(input logic c, input logic [3:0] v);
    return c ? v + {3'h0, v != 4'hf} : 4'h0;
  endfunction : sat

  // a glitch restarts a count, so no short pulse satisfies a hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {clrLo_q, clrHi_q, dim_q, ceLo_q, quiet_q} <= '0;
    end else begin
      clrLo_q <= sat(!clearPinN, clrLo_q);
      clrHi_q <= sat(clearPinN, clrHi_q);
      dim_q   <= sat(dim_all_in, dim_q);
      ceLo_q  <= sat(!chipEnableN, ceLo_q);
      quiet_q <= sat($stable(serialClk) && $stable(serialIn) && $stable(chipEnableN) && $stable(clearPinN), quiet_q);
    end
  end

  a_reset_dark: assert property ($rose(rst_n) |-> ledDrive == '0 && peakCurrent == '0)
    else $error("outputs not dark after reset");
  a_clear_sleeps: assert property (clrLo_q >= 4'h8 |-> ledDrive == '0 && peakCurrent == '0)
    else $error("clear pin did not force sleep");
  a_dim_blanks: assert property (dim_q >= 4'h8 |-> ledDrive == '0)
    else $error("leds lit while dimmed");
  a_tick_driven: assert property (oscSelect [*8] |-> display_tick_pin_oe)
    else $error("tick pin not driven on internal timing");
  a_tick_input: assert property ((!oscSelect) [*8] |-> !display_tick_pin_oe && !display_tick_pin_out)
    else $error("tick pin driven on external timing");
  a_peak_hold: assert property (ceLo_q >= 4'ha && clrHi_q >= 4'ha |-> $stable(peakCurrent))
    else $error("control word moved during a write");
  a_dout_quiet: assert property (quiet_q >= 4'hc |-> $stable(serialOut))
    else $error("serial out moved without a cause");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");

  cover property (ledDrive != '0);
  cover property (pready && pslverr);
  cover property ($fell(display_tick_pin_oe));
endmodule : slml_checker

bind slml_loader slml_checker #(.DOT_N(DOT_N)) slml_checker_i (
  .clk(clk), .rst_n(rst_n), .serialClk(serialClk), .serialIn(serialIn), .chipEnableN(chipEnableN),
  .clearPinN(clearPinN), .oscSelect(oscSelect), .dim_all_in(dim_all_in), .serialOut(serialOut),
  .display_tick_pin_out(display_tick_pin_out), .display_tick_pin_oe(display_tick_pin_oe),
  .ledDrive(ledDrive), .peakCurrent(peakCurrent), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr));

// File: tb/slml_host_model.sv
// host model: drives the serial pins of the loader in whole frames
// assumes clk is the bench clock; serial clock kept under 5 MHz
`timescale 1ns/1ns
module slml_host_model (
  input  wire logic clk,
  output logic      serialClk,
  output logic      serialIn,
  output logic      chipEnableN,
  output logic      target_choice
);
  localparam int HALF = 13;  // clk cycles per serial clock high phase, 104 ns; the low phase is 6 more

  // idle: clock still and low, enable high
  initial begin
    serialClk     = 1'b0;
    serialIn      = 1'b0;
    chipEnableN   = 1'b1;
    target_choice = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause

  // one frame, msb first; select flips after the enable fall on purpose
  task automatic frame(input logic rs, input int n, input logic [159:0] bits);
    target_choice <= rs;
    pause(4);
    chipEnableN <= 1'b0;
    pause(6);
    target_choice <= ~rs;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn  <= bits[i];
      pause(6);
      serialClk <= 1'b1;
      pause(HALF);
      serialClk <= 1'b0;
      pause(HALF);
    end
    chipEnableN <= 1'b1;
    serialIn    <= ~serialIn;  // a released line keeps no value
    pause(12);
  endtask : frame

  // fills the whole 160-bit dot register in one frame
  task automatic sendDots(input logic [159:0] dots);
    frame(1'b0, 160, dots);
  endtask : sendDots

  task automatic sendCtrl(input logic [7:0] word);
    frame(1'b1, 8, {152'h0, word});
  endtask : sendCtrl
endmodule : slml_host_model

// File: tb/test_slml_loader.sv
// self-checking bench of the loader: registers, serial loads, blanking, clear
// assumes the host model drives the serial pins and the checker is bound in
`timescale 1ns/1ns
module test_slml_loader;
  localparam logic [159:0] PAT = 160'h80a51234_56789abc_def00f1e_2d3c4b5a_6978c001;
  logic         clk = 1'b0, rst_n = 1'b0, clearPinN = 1'b1, oscSelect = 1'b1, dimAll = 1'b0, extOsc = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic         sClk, sIn, ceN, tgt, sOut, tickOut, tickOe, tickPin;
  logic [7:0]   paddr = 8'h0;
  logic [4:0]   extCnt = 5'h0;
  logic [1:0]   peak;
  logic [31:0]  pwdata = 32'h0, prdata, rdata;
  logic [159:0] leds;
  int           failures = 0, check_count = 0;

  // whoever enables the tick pin drives it, else the bench oscillator
  assign tickPin = tickOe ? tickOut : extOsc;

  slml_loader slml_loader_i (.clk(clk), .rst_n(rst_n), .serialClk(sClk), .serialIn(sIn), .chipEnableN(ceN),
    .target_choice(tgt), .clearPinN(clearPinN), .oscSelect(oscSelect), .dim_all_in(dimAll), .serialOut(sOut),
    .display_tick_pin_in(tickPin), .display_tick_pin_out(tickOut), .display_tick_pin_oe(tickOe),
    .ledDrive(leds), .peakCurrent(peak), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  slml_host_model slml_host_model_i (.clk(clk), .serialClk(sClk), .serialIn(sIn), .chipEnableN(ceN),
    .target_choice(tgt));

  initial begin
    forever #4 clk = ~clk;
  end

  // external display oscillator, 64 clk period
  always @(posedge clk) begin
    extCnt <= extCnt + 5'h1;
    extOsc <= (extCnt == 5'h1f) ? ~extOsc : extOsc;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic timedOut(input logic bad);
    if (bad) begin
      failures++;
      $display("wrong value at %0t: wait ran out", $time);
      conclude();
    end
  endtask : timedOut

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    timedOut(pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // pwm may darken leds briefly, so wait for a lit phase
  task automatic waitLit();
    int n;
    n = 0;
    while (leds === '0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    timedOut(leds === '0);
  endtask : waitLit

  task automatic scnRegs();
    apb(1'b0, 8'h00, 32'h0);
    check(rdata[16:0], 17'h10000);
    apb(1'b0, 8'h04, 32'h0);
    check(rdata, 32'h1a0);
    apb(1'b1, 8'h04, 32'h20);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check({err, rdata}, 33'h20);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    check(err, 1'b1);
  endtask : scnRegs

  task automatic scnLoad();
    slml_host_model_i.sendDots('0);
    slml_host_model_i.sendCtrl(8'h7f);
    check(peak, 2'h3);
    check(sOut, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check(rdata[16:0], 17'h0007f);
    slml_host_model_i.sendDots(PAT);
    waitLit();
    check(leds, PAT);
    check(sOut, 1'b1);
    // top word of the latch read back through the debug window
    apb(1'b1, 8'h08, 32'h4);
    apb(1'b0, 8'h0c, 32'h0);
    check({err, rdata}, {1'b0, PAT[159:128]});
  endtask : scnLoad

  task automatic scnCtrl1();
    slml_host_model_i.sendCtrl(8'h80);
    check(sOut, 1'b1);
    check(peak, 2'h3);
    apb(1'b0, 8'h00, 32'h0);
    check(rdata[14:0], 15'h007f);
    waitLit();
    check(leds, PAT);
  endtask : scnCtrl1

  task automatic scnDimTick();
    dimAll <= 1'b1;
    repeat (10) @(posedge clk);
    check(leds, '0);
    dimAll <= 1'b0;
    waitLit();
    check(leds, PAT);
    check(tickOe, 1'b1);
    // simultaneous data out and prescaled external timebase
    slml_host_model_i.sendCtrl(8'h83);
    check(sOut, 1'b0);
    oscSelect <= 1'b0;
    repeat (10) @(posedge clk);
    check({tickOe, tickOut}, 2'h0);
    waitLit();
    check(leds, PAT);
    oscSelect <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : scnDimTick

  task automatic scnClear();
    clearPinN <= 1'b0;
    repeat (10) @(posedge clk);
    check(leds, '0);
    check(peak, 2'h0);
    clearPinN <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    check(rdata[16:0], 17'h10000);
    slml_host_model_i.sendCtrl(8'h7f);
    waitLit();
    check(leds, PAT);
  endtask : scnClear

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    scnRegs();
    scnLoad();
    scnCtrl1();
    scnDimTick();
    scnClear();
    conclude();
  end
endmodule : test_slml_loader
